// file: scg_ctrl.v
// Sleep clock gating controller: gating register set, per-unit clock enables,
// and a bus fault check for accesses to units whose clock is off.
// Assumes one system clock, a synchronous active-high reset, an AXI4-Lite master
// and a sleep request level that arrives from the power controller's own timing.
//
// Function
// RL1: A set gating bit clocks its unit; a clear bit stops the unit's clock.
// RL2: An access to a unit whose clock is off is answered with a bus fault.
// RL3: The sleep gating register resets to 0x00000040, all other gate bits zero.
// RL4: Bit 6 gates the hibernation unit, read-write, reset to one.
// RL5: Bit 20 gates the pulse-width modulator, reset zero, faulting while clear.
// RL6: Bit 16 gates the converter, reset zero, faulting while clear.
// RL7: Bit 3 gates the watchdog, reset zero, faulting while clear.
// RL8: Bits 9:8 set converter sample rate, 3=1M, 2=500K, 1=250K, 0=125K, reset 0.
// RL9: Software never programs a sample rate above the converter's maximum.
// RL10: Reserved bits are read-only zero and software preserves them on update.
// RL11: The sleep register governs clocks in sleep; run gates govern running.
// RL12: The sleep register acts only while the auto gating bit is set.
// RL13: Software enables every unit it needs, since all but the hibernation unit start disabled.
// RL14: With auto gating clear, the run gates also govern sleep.
`timescale 1ns/1ps
`include "scg_map.vh"

module scg_ctrl #(
  parameter UNITS = `SCG_NUM_UNITS
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  // AXI4-Lite slave
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // System state and unit access checking
  input  wire             sleep_i,
  input  wire             unit_req_i,
  input  wire [UNITS-1:0] unit_sel_i,
  output reg              unit_fault_o,
  output reg              unit_ok_o,
  // Unit clock enables and converter rate
  output reg  [UNITS-1:0] unit_clk_en_o,
  output reg  [1:0]       converter_sample_rate_o,
  output reg              irq_o
);

  // ==========================================================================
  // Registers and state
  // ==========================================================================
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RESP = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg  [31:0]             sleep_clock_gate_0_q;
  reg  [31:0]             run_clock_gate_0_q;
  reg  [31:0]             run_clock_config_q;
  reg  [`SCG_IRQ_WIDTH-1:0] irq_status_q;
  reg  [`SCG_IRQ_WIDTH-1:0] irq_mask_q;
  reg  [UNITS-1:0]        fault_unit_q;
  reg  [2:0]              wr_state_q;
  reg  [11:0]             aw_addr_q;
  reg                     aw_have_q;
  reg  [31:0]             w_data_q;
  reg  [3:0]              w_strb_q;
  reg                     w_have_q;
  wire                    sleep_sync;
  wire [31:0]             wr_bytes;
  reg  [31:0]             rd_val;
  reg                     rd_hit;
  reg                     wr_hit;
  reg  [UNITS-1:0]        gate_vec;
  reg  [UNITS-1:0]        clk_en_d;
  wire                    wr_fire;
  wire                    fault_evt;
  wire                    cfg_evt;
  wire                    auto_gating;

  // Sleep request comes from another clock region, so it is synchronised
  scg_sync2 u_sleep_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (sleep_i),
    .q_o   (sleep_sync)
  );

  assign auto_gating = run_clock_config_q[`SCG_BIT_AUTO_GATING];

  // ==========================================================================
  // Clock enable selection
  // ==========================================================================
  // Pick the gate word in force: sleep word only under auto gating in sleep
  always @* begin
    gate_vec = {UNITS{1'b0}};
    clk_en_d = {UNITS{1'b0}};
    if (sleep_sync && auto_gating) begin                         // RL11 RL12
      gate_vec[`SCG_UNIT_WATCHDOG]  = sleep_clock_gate_0_q[`SCG_BIT_WATCHDOG];   // RL7
      gate_vec[`SCG_UNIT_HIBERNATE] = sleep_clock_gate_0_q[`SCG_BIT_HIBERNATE];  // RL4
      gate_vec[`SCG_UNIT_CONVERTER] = sleep_clock_gate_0_q[`SCG_BIT_CONVERTER];  // RL6
      gate_vec[`SCG_UNIT_PWM]       = sleep_clock_gate_0_q[`SCG_BIT_PWM];        // RL5
    end else begin                                               // RL14
      gate_vec[`SCG_UNIT_WATCHDOG]  = run_clock_gate_0_q[`SCG_BIT_WATCHDOG];
      gate_vec[`SCG_UNIT_HIBERNATE] = run_clock_gate_0_q[`SCG_BIT_HIBERNATE];
      gate_vec[`SCG_UNIT_CONVERTER] = run_clock_gate_0_q[`SCG_BIT_CONVERTER];
      gate_vec[`SCG_UNIT_PWM]       = run_clock_gate_0_q[`SCG_BIT_PWM];
    end
    clk_en_d = gate_vec;                                         // RL1
  end

  // Registered enables; a glitch-free cell downstream uses them
  always @(posedge clk_i) begin
    if (rst_i) begin
      unit_clk_en_o           <= {UNITS{1'b0}};
      converter_sample_rate_o <= 2'h0;
    end else if (ce_i) begin
      unit_clk_en_o <= clk_en_d;                                 // RL1
      if (sleep_sync && auto_gating) begin
        converter_sample_rate_o <=
          sleep_clock_gate_0_q[`SCG_RATE_HI:`SCG_RATE_LO];       // RL8
      end else begin
        converter_sample_rate_o <=
          run_clock_gate_0_q[`SCG_RATE_HI:`SCG_RATE_LO];
      end
    end
  end

  // ==========================================================================
  // Unit access fault check
  // ==========================================================================
  // Checked against the enables the unit sees now, not the pending ones
  assign fault_evt = unit_req_i && ((unit_sel_i & ~unit_clk_en_o) != {UNITS{1'b0}});

  always @(posedge clk_i) begin
    if (rst_i) begin
      unit_fault_o <= 1'b0;
      unit_ok_o    <= 1'b0;
      fault_unit_q <= {UNITS{1'b0}};
    end else if (ce_i) begin
      unit_fault_o <= fault_evt;                                 // RL2 RL5 RL6 RL7
      unit_ok_o    <= unit_req_i && !fault_evt;
      if (fault_evt) begin
        fault_unit_q <= unit_sel_i & ~unit_clk_en_o;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  assign wr_fire  = (wr_state_q == ST_IDLE) && aw_have_q && w_have_q;
  assign wr_bytes = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign cfg_evt  = wr_fire && wr_hit;

  // Address decode of the write
  always @* begin
    wr_hit = 1'b0;
    if (aw_addr_q == `SCG_OFF_SLEEP_GATE) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == `SCG_OFF_RUN_GATE) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == `SCG_OFF_RUN_CFG) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == `SCG_OFF_IRQ_STATUS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == `SCG_OFF_IRQ_MASK) begin
      wr_hit = 1'b1;
    end else if (aw_addr_q == `SCG_OFF_FAULT_ADDR) begin
      wr_hit = 1'b1;
    end
  end

  // Address and data are taken in either order, then one response
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_state_q    <= ST_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SCG_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end else if (ce_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wr_state_q)
        ST_IDLE: begin
          if (!aw_have_q && s_axi_awvalid && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
          end
          if (!w_have_q && s_axi_wvalid && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            w_have_q     <= 1'b1;
          end
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
            wr_state_q   <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            wr_state_q   <= ST_IDLE;
          end
        end
        default: begin
          wr_state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Register storage and interrupts
  // ==========================================================================
  // Reserved bits never store, so they read back zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      sleep_clock_gate_0_q <= `SCG_GATE_RESET;                   // RL3 RL4
      run_clock_gate_0_q   <= `SCG_GATE_RESET;
      run_clock_config_q   <= `SCG_CFG_RESET;
      irq_mask_q           <= {`SCG_IRQ_WIDTH{1'b0}};
      irq_status_q         <= {`SCG_IRQ_WIDTH{1'b0}};
      irq_o                <= 1'b0;
    end else if (ce_i) begin
      if (wr_fire && aw_addr_q == `SCG_OFF_SLEEP_GATE) begin
        sleep_clock_gate_0_q <= (sleep_clock_gate_0_q & ~(wr_bytes & `SCG_GATE_WMASK)) |
                                (w_data_q & wr_bytes & `SCG_GATE_WMASK);  // RL10
      end
      if (wr_fire && aw_addr_q == `SCG_OFF_RUN_GATE) begin
        run_clock_gate_0_q <= (run_clock_gate_0_q & ~(wr_bytes & `SCG_GATE_WMASK)) |
                              (w_data_q & wr_bytes & `SCG_GATE_WMASK);
      end
      if (wr_fire && aw_addr_q == `SCG_OFF_RUN_CFG) begin
        run_clock_config_q <= (run_clock_config_q & ~(wr_bytes & `SCG_CFG_WMASK)) |
                              (w_data_q & wr_bytes & `SCG_CFG_WMASK);
      end
      if (wr_fire && aw_addr_q == `SCG_OFF_IRQ_MASK && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[`SCG_IRQ_WIDTH-1:0];
      end
      // Write-one-to-clear; a new event in the same cycle wins
      irq_status_q[`SCG_IRQ_FAULT] <= fault_evt ||
        (irq_status_q[`SCG_IRQ_FAULT] && !(wr_fire && w_strb_q[0] &&
         aw_addr_q == `SCG_OFF_IRQ_STATUS && w_data_q[`SCG_IRQ_FAULT]));
      irq_status_q[`SCG_IRQ_CFG_CHG] <= (unit_clk_en_o != clk_en_d) ||
        (irq_status_q[`SCG_IRQ_CFG_CHG] && !(wr_fire && w_strb_q[0] &&
         aw_addr_q == `SCG_OFF_IRQ_STATUS && w_data_q[`SCG_IRQ_CFG_CHG]));
      irq_o <= (irq_status_q & irq_mask_q) != {`SCG_IRQ_WIDTH{1'b0}};
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  // Read decode; unmapped addresses answer zero with a slave error
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `SCG_OFF_SLEEP_GATE) begin
      rd_val = sleep_clock_gate_0_q;                             // RL10
    end else if (s_axi_araddr == `SCG_OFF_RUN_GATE) begin
      rd_val = run_clock_gate_0_q;
    end else if (s_axi_araddr == `SCG_OFF_RUN_CFG) begin
      rd_val = run_clock_config_q;
    end else if (s_axi_araddr == `SCG_OFF_IRQ_STATUS) begin
      rd_val[`SCG_IRQ_WIDTH-1:0] = irq_status_q;
    end else if (s_axi_araddr == `SCG_OFF_IRQ_MASK) begin
      rd_val[`SCG_IRQ_WIDTH-1:0] = irq_mask_q;
    end else if (s_axi_araddr == `SCG_OFF_FAULT_ADDR) begin
      rd_val[UNITS-1:0] = fault_unit_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One read in flight; data follow the address handshake, never precede it
  always @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SCG_RESP_OKAY;
    end else if (ce_i) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
      end else if (s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // scg_ctrl

// file: scg_map.vh
// Register map, field positions and reset values of the sleep clock gating block.
// Included by the controller and its bench; definitions only.
`ifndef SCG_MAP_VH
`define SCG_MAP_VH

// Register byte offsets (12-bit decode)
`define SCG_OFF_SLEEP_GATE   12'h110
`define SCG_OFF_RUN_GATE     12'h100
`define SCG_OFF_RUN_CFG      12'h060
`define SCG_OFF_IRQ_STATUS   12'h200
`define SCG_OFF_IRQ_MASK     12'h204
`define SCG_OFF_FAULT_ADDR   12'h208

// Sleep gate fields
`define SCG_BIT_WATCHDOG     3
`define SCG_BIT_HIBERNATE    6
`define SCG_RATE_LO          8
`define SCG_RATE_HI          9
`define SCG_BIT_CONVERTER    16
`define SCG_BIT_PWM          20
`define SCG_GATE_WMASK       32'h0011_0348
`define SCG_GATE_RESET       32'h0000_0040

// Run clock config fields
`define SCG_BIT_AUTO_GATING  27
`define SCG_CFG_WMASK        32'h0800_0000
`define SCG_CFG_RESET        32'h0000_0000

// Unit indices on the unit select vector
`define SCG_UNIT_WATCHDOG    0
`define SCG_UNIT_HIBERNATE   1
`define SCG_UNIT_CONVERTER   2
`define SCG_UNIT_PWM         3
`define SCG_NUM_UNITS        4

// Interrupt status bits
`define SCG_IRQ_FAULT        0
`define SCG_IRQ_WIDTH        2
`define SCG_IRQ_CFG_CHG      1

// AXI responses
`define SCG_RESP_OKAY        2'h0
`define SCG_RESP_SLVERR      2'h2

`endif

// file: scg_sync2.v
// Two-flop synchroniser for one level arriving from outside the clock domain.
// Assumes the same clock and clock enable as the block that reads it.
`timescale 1ns/1ps

module scg_sync2 (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire d_i,
  output wire q_o
);

  reg meta_q;
  reg sync_q;

  // First stage is read only by the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // scg_sync2

// file: scg_ctrl_props.sv
// Checker for the sleep clock gating controller ports.
// Assumes one clock, ce_i held high by the bench, synchronous reset rst_i.
`timescale 1ns/1ps

// ==========================================
// Port checker
module scg_ctrl_props #(
  parameter UNITS = 4
) (
  input wire             clk_i,
  input wire             rst_i,
  input wire             ce_i,
  input wire             s_axi_awvalid,
  input wire             s_axi_wvalid,
  input wire [1:0]       s_axi_bresp,
  input wire             s_axi_bvalid,
  input wire             s_axi_bready,
  input wire             s_axi_arready,
  input wire [31:0]      s_axi_rdata,
  input wire             s_axi_rvalid,
  input wire             s_axi_rready,
  input wire             unit_req_i,
  input wire [UNITS-1:0] unit_sel_i,
  input wire             unit_fault_o,
  input wire             unit_ok_o,
  input wire [UNITS-1:0] unit_clk_en_o,
  input wire             irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Access answers tie to the enables seen on the request cycle
  a_fault_when_off: assert property (unit_req_i && ce_i && |(unit_sel_i & ~unit_clk_en_o)
    |=> unit_fault_o) else $error("access to a stopped unit not faulted");
  a_ok_when_on: assert property (unit_req_i && ce_i && $onehot(unit_sel_i)
    && (unit_sel_i & ~unit_clk_en_o) == 0 |=> unit_ok_o && !unit_fault_o)
    else $error("access to a clocked unit not accepted");
  a_idle_quiet: assert property (!unit_req_i && ce_i |=> !unit_fault_o && !unit_ok_o)
    else $error("unit answer without a request");
  a_answer_excl: assert property (!(unit_fault_o && unit_ok_o))
    else $error("fault and accept together");
  // Bus answers after reset, holding, and bounded latency
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property ($fell(s_axi_arready) |-> s_axi_rvalid)
    else $error("read data not after address accept");

  c_fault: cover property (unit_fault_o);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_irq: cover property (irq_o);
endmodule // scg_ctrl_props

bind scg_ctrl scg_ctrl_props #(.UNITS(UNITS)) u_scg_ctrl_props (.clk_i, .rst_i, .ce_i,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .unit_req_i,
  .unit_sel_i, .unit_fault_o, .unit_ok_o, .unit_clk_en_o, .irq_o);

// file: scg_unit_model.sv
// Far side: a master touching one gated unit per request.
// Assumes the controller answers one cycle after each request cycle.
`timescale 1ns/1ps

// ==========================================
// Unit access model
module scg_unit_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        go_i,
  input  wire  [3:0] sel_i,
  input  wire        unit_fault_i,
  input  wire        unit_ok_i,
  output logic       unit_req_o,
  output logic [3:0] unit_sel_o,
  output logic [1:0] resp_o,
  output logic       done_o
);
  logic pend_q;

  // Answer is latched in its single cycle and held for the bench
  always @(posedge clk_i) begin
    if (rst_i) begin
      unit_req_o <= 1'b0;
      unit_sel_o <= 4'h0;
      pend_q     <= 1'b0;
      resp_o     <= 2'h0;
      done_o     <= 1'b0;
    end else begin
      unit_req_o <= go_i;
      unit_sel_o <= go_i ? sel_i : ~unit_sel_o; // Idle lines toggle between the last unit and its complement
      pend_q     <= unit_req_o;
      if (pend_q) resp_o <= {unit_fault_i, unit_ok_i};
      done_o     <= go_i ? 1'b0 : (done_o | pend_q);
    end
  end
endmodule // scg_unit_model

// file: sleep_clock_gating_ctrl0_test.sv
// Self-checking bench for the sleep clock gating controller.
// Assumes the register map header and the unit model are compiled alongside.
`timescale 1ns/1ps
`include "scg_map.vh"

// ==========================================
// Bench
module sleep_clock_gating_ctrl0_test;
  localparam [1:0] MAX_RATE = 2'h3; // Highest code the converter supports
  logic clk_i = 0, rst_i = 1, sleep_i = 0, go = 0, auto_q = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, w, slp_w, run_w, rdat;
  logic [3:0] s_axi_wstrb = 0, sel = 0, e, s;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire unit_req_i, unit_fault_o, unit_ok_o, irq_o, done;
  wire [1:0] s_axi_bresp, s_axi_rresp, rate, uresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] unit_sel_i, clk_en;
  int failures = 0, num_checks = 0, i, u;

  always #20 clk_i = ~clk_i;

  scg_ctrl u_scg_ctrl (.clk_i, .rst_i, .ce_i(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep_i, .unit_req_i, .unit_sel_i, .unit_fault_o, .unit_ok_o,
    .unit_clk_en_o(clk_en), .converter_sample_rate_o(rate), .irq_o);
  scg_unit_model u_scg_unit_model (.clk_i, .rst_i, .go_i(go), .sel_i(sel),
    .unit_fault_i(unit_fault_o), .unit_ok_i(unit_ok_o), .unit_req_o(unit_req_i),
    .unit_sel_o(unit_sel_i), .resp_o(uresp), .done_o(done));

  // Comparisons and the end of the run
  task automatic chk_word(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: response %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Expected register contents after a strobed write; same layout for both gate words
  function automatic logic [31:0] mrg(input logic [31:0] o, d, input logic [3:0] st);
    for (int b = 0; b < 4; b++) if (st[b]) o[8*b+:8] = d[8*b+:8];
    return o & `SCG_GATE_WMASK;
  endfunction
  function automatic logic [3:0] en_of(input logic [31:0] g);
    return {g[20], g[16], g[6], g[3]};
  endfunction

  // Bus cycles; a missing answer leaves response 1, which never matches
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    int k;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    r = 2'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin r = s_axi_bresp; break; end
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_i); // Lets bready settle low before the next request
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int k;
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    r = 2'h1;
    rdat = 32'hdead_beef;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin rdat = s_axi_rdata; r = s_axi_rresp; break; end
    end
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
    chk_word(rdat, exp);
    chk_resp(r, er);
  endtask
  // One unit access through the far-side model
  task automatic acc(input int un, input logic fault);
    int k;
    go <= 1'b1; sel <= 4'h1 << un;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    for (k = 0; k < 10 && done !== 1'b1; k++) @(posedge clk_i);
    chk_resp(uresp, {fault, !fault});
  endtask

  // Main sequence: reset values, refusals, interrupt, then random gate words
  initial begin
    void'($urandom(43));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    slp_w = 32'h40; run_w = 32'h40;
    rd(`SCG_OFF_SLEEP_GATE, 32'h40, `SCG_RESP_OKAY);
    rd(`SCG_OFF_RUN_GATE, 32'h40, `SCG_RESP_OKAY);
    rd(12'h3fc, 32'h0, `SCG_RESP_SLVERR);
    wr(12'h3fc, 32'hffff_ffff, 4'hf); chk_resp(r, `SCG_RESP_SLVERR);
    acc(`SCG_UNIT_WATCHDOG, 1'b1);
    rd(`SCG_OFF_FAULT_ADDR, 32'h1, `SCG_RESP_OKAY);
    chk_word({31'h0, irq_o}, 32'h0);
    wr(`SCG_OFF_IRQ_MASK, 32'h1, 4'hf);
    repeat (3) @(posedge clk_i);
    chk_word({31'h0, irq_o}, 32'h1);
    for (i = 0; i < 6; i++) begin
      w = (i == 0) ? 32'hffff_ffff : $urandom;
      if (w[9:8] > MAX_RATE) w[9:8] = MAX_RATE;
      s = (i == 5) ? 4'b0100 : 4'hf;
      wr(`SCG_OFF_SLEEP_GATE, w, s); slp_w = mrg(slp_w, w, s);
      rd(`SCG_OFF_SLEEP_GATE, slp_w, `SCG_RESP_OKAY);
      w = $urandom; w[9:8] = i[1:0];
      wr(`SCG_OFF_RUN_GATE, w, 4'hf); run_w = mrg(run_w, w, 4'hf);
      auto_q = (i == 1) ? 1'b1 : (i == 2) ? 1'b0 : 1'($urandom); // Both word sources met
      sleep_i <= (i < 3) ? (i != 0) : 1'($urandom);
      wr(`SCG_OFF_RUN_CFG, {4'h0, auto_q, 27'h0}, 4'hf);
      wr(`SCG_OFF_IRQ_STATUS, 32'h3, 4'hf);
      repeat (4) @(posedge clk_i);
      w = (sleep_i && auto_q) ? slp_w : run_w;
      e = en_of(w);
      chk_word({28'h0, clk_en}, {28'h0, e});
      chk_word({30'h0, rate}, {30'h0, w[9:8]});
      for (u = 0; u < 4; u++) acc(u, !e[u]);
      repeat (3) @(posedge clk_i);
      chk_word({31'h0, irq_o}, {31'h0, e != 4'hf});
    end
    complete_run;
  end

  // Run needs well under 2000 cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run;
  end
endmodule // sleep_clock_gating_ctrl0_test
